// file: logic/direction_and_test_control.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module direction_and_test_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sensor_pulse_one,
  input wire logic sensor_pulse_two,
  input wire logic sensor_pulse_three,
  input wire logic freq_input_one,
  input wire logic freq_input_two,
  input wire logic freq_input_three,
  input wire logic [5:0] binary_in,
  input wire dtc_pkg::health_in_t health_in,
  output logic [6:0] relay_out,
  output logic [2:0] freq_out,
  output logic freq_input_test,
  output logic [2:0] monitor_in,
  output logic peak_hold_clear,
  output dtc_pkg::leds_t leds
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] cfg_dir_ff;
  logic [31:0] cfg_relay_ff;
  logic [31:0] cfg_bin_ff;
  logic [31:0] cfg_fout_ff;
  logic [7:0] host_cmd_ff;
  logic [31:0] test_div_ff;
  logic [3:0] latch_cfg_ff;
  logic [7:0] health_status_word;
  logic [7:0] host_command_word;
  logic wr_en;
  logic fwd_state_ff;
  logic test_active;
  logic [3:0] msg_ff;
  logic system_healthy;
  logic module_healthy;
  logic supplies_healthy;
  logic failure_command;

  assign wr_en = psel && penable && pwrite;

  // Configuration and host command writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_dir_ff <= dtc_pkg::CFG_DIR_RST;
      cfg_relay_ff <= dtc_pkg::CFG_RELAY_RST;
      cfg_bin_ff <= dtc_pkg::CFG_BIN_RST;
      cfg_fout_ff <= dtc_pkg::CFG_FOUT_RST;
      test_div_ff <= dtc_pkg::TEST_DIV_RST;
      host_cmd_ff <= 8'h00;
      latch_cfg_ff <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        dtc_pkg::CFG_DIR_OFF: cfg_dir_ff <= pwdata;
        dtc_pkg::CFG_RELAY_OFF: cfg_relay_ff <= pwdata;
        dtc_pkg::CFG_BIN_OFF: cfg_bin_ff <= pwdata;
        dtc_pkg::CFG_FOUT_OFF: cfg_fout_ff <= pwdata;
        dtc_pkg::CMD_OFF: host_cmd_ff <= pwdata[7:0];
        dtc_pkg::TEST_DIV_OFF: test_div_ff <= pwdata;
        dtc_pkg::LATCH_CFG_OFF: latch_cfg_ff <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Read mux, zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          dtc_pkg::CFG_DIR_OFF: prdata <= cfg_dir_ff;
          dtc_pkg::CFG_RELAY_OFF: prdata <= cfg_relay_ff;
          dtc_pkg::CFG_BIN_OFF: prdata <= cfg_bin_ff;
          dtc_pkg::CFG_FOUT_OFF: prdata <= cfg_fout_ff;
          dtc_pkg::CMD_OFF: prdata <= {24'h00_0000, host_command_word};
          dtc_pkg::STATUS_OFF: prdata <= {24'h00_0000, health_status_word};
          dtc_pkg::TEST_DIV_OFF: prdata <= test_div_ff;
          dtc_pkg::HEALTH_OFF: prdata <= {28'h000_0000, msg_ff};
          dtc_pkg::LATCH_CFG_OFF: prdata <= {28'h000_0000, latch_cfg_ff};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Binary input synchronisers and command mapping
  logic [5:0] bin_s1_ff, bin_s2_ff, bin_s3_ff, bin_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_s1_ff <= 6'h00;
      bin_s2_ff <= 6'h00;
      bin_s3_ff <= 6'h00;
      bin_ff <= 6'h00;
    end else begin
      bin_s1_ff <= binary_in;
      bin_s2_ff <= bin_s1_ff;
      bin_s3_ff <= bin_s2_ff;
      for (int i = 0; i < 6; i++) begin
        if (bin_s2_ff[i] == bin_s3_ff[i]) bin_ff[i] <= bin_s3_ff[i];
      end
    end
  end

  // Each binary input mapped to a command forces that bit to its level; BIN_NONE and BIN_TEST_ACTIVE drive no bit
  always_comb begin
    host_command_word = host_cmd_ff;
    for (int i = 0; i < 6; i++) begin
      case (dtc_pkg::bin_func_t'(cfg_bin_ff[4*i +: 4]))
        dtc_pkg::BIN_ACK: host_command_word[dtc_pkg::CMD_ACK] = bin_ff[i];
        dtc_pkg::BIN_PEAK_CLR: host_command_word[dtc_pkg::CMD_PEAK_CLR] = bin_ff[i];
        dtc_pkg::BIN_CHECK: host_command_word[dtc_pkg::CMD_CHECK] = bin_ff[i];
        dtc_pkg::BIN_FWD_FORCE: host_command_word[dtc_pkg::CMD_FWD_FORCE] = bin_ff[i];
        dtc_pkg::BIN_SEL_LOW: host_command_word[dtc_pkg::CMD_SEL_LOW] = bin_ff[i];
        dtc_pkg::BIN_SEL_HIGH: host_command_word[dtc_pkg::CMD_SEL_HIGH] = bin_ff[i];
        dtc_pkg::BIN_LEVEL: host_command_word[dtc_pkg::CMD_LEVEL] = bin_ff[i];
        dtc_pkg::BIN_RUN: host_command_word[dtc_pkg::CMD_RUN] = bin_ff[i];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sensor synchronisation and phase order
  logic [2:0] sp_s1_ff, sp_s2_ff, sp_s3_ff, sp_ff, sp_prev_ff;
  logic [2:0] rise;
  logic [2:0] last_ff; // One-hot mask of last rising sensor
  logic [2:0] lead_ff; // lead_ff[k]: sensor k led its successor last time
  logic [2:0] fitted;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_s1_ff <= 3'h0;
      sp_s2_ff <= 3'h0;
      sp_s3_ff <= 3'h0;
      sp_ff <= 3'h0;
      sp_prev_ff <= 3'h0;
    end else begin
      sp_s1_ff <= {sensor_pulse_three, sensor_pulse_two, sensor_pulse_one};
      sp_s2_ff <= sp_s1_ff;
      sp_s3_ff <= sp_s2_ff;
      for (int i = 0; i < 3; i++) begin
        if (sp_s2_ff[i] == sp_s3_ff[i]) sp_ff[i] <= sp_s3_ff[i];
      end
      sp_prev_ff <= sp_ff;
    end
  end

  assign rise = sp_ff & ~sp_prev_ff;
  // Fitted sensors: bit set in direction config [4:2]
  assign fitted = cfg_dir_ff[4:2];

  // At a rise, a predecessor still high leads this sensor and a successor
  // still low lags it; levels, not rise order, so two sensors also decide.
  // A lost sensor sits low and pins two lead bits, one forward and one backward.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= 3'h0;
      lead_ff <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (rise[k] && fitted[k]) begin
          last_ff <= 3'(1 << k);
          lead_ff[(k + 2) % 3] <= sp_ff[(k + 2) % 3];
          lead_ff[k] <= !sp_ff[(k + 1) % 3];
        end
      end
    end
  end

  // Forward decision from fitted pairs
  logic pair_fwd;
  logic pair_bwd;
  logic raw_fwd;
  always_comb begin
    pair_fwd = 1'b0;
    pair_bwd = 1'b0;
    if (&fitted) begin
      // All three leads agree; with one lost the remaining leads decide
      pair_fwd = (lead_ff == 3'h7) || ($countones(lead_ff) == 2);
      pair_bwd = (lead_ff == 3'h0) || ($countones(lead_ff) == 1);
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (fitted[k] && fitted[(k + 1) % 3]) begin
          pair_fwd = lead_ff[k];
          pair_bwd = !lead_ff[k];
        end
      end
    end
    raw_fwd = pair_fwd ^ cfg_dir_ff[1];
  end

  // Direction state: default on reset, forced forward by command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_state_ff <= dtc_pkg::CFG_DIR_RST[0];
    end else if (host_command_word[dtc_pkg::CMD_FWD_FORCE]) begin
      fwd_state_ff <= 1'b1;
    end else if (|last_ff && (pair_fwd || pair_bwd)) begin
      fwd_state_ff <= raw_fwd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Health, latching messages and acknowledge
  logic ack_prev_ff;
  logic ack_done;
  logic [3:0] msg_live;
  assign msg_live = {module_healthy, health_in.sensor_healthy,
                     health_in.supply_two_healthy, health_in.supply_one_healthy};
  assign ack_done = ack_prev_ff && !host_command_word[dtc_pkg::CMD_ACK];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ff <= 4'hF;
      ack_prev_ff <= 1'b0;
    end else begin
      ack_prev_ff <= host_command_word[dtc_pkg::CMD_ACK];
      for (int i = 0; i < 4; i++) begin
        // Fault wins over the acknowledge clear
        if (!msg_live[i]) msg_ff[i] <= 1'b0;
        else if (!latch_cfg_ff[i] || ack_done) msg_ff[i] <= 1'b1;
      end
    end
  end

  assign supplies_healthy = msg_ff[0] & msg_ff[1];
  assign module_healthy = health_in.self_test_ok & health_in.sensor_healthy & supplies_healthy;
  assign system_healthy = health_in.self_test_ok & msg_ff[2] & supplies_healthy;
  assign failure_command = health_in.self_test_ok & msg_ff[0] & msg_ff[1] & msg_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Test generator
  logic [31:0] gen_cnt_ff;
  logic gen_ff;
  logic [1:0] mon_sel;
  assign mon_sel = {host_command_word[dtc_pkg::CMD_SEL_HIGH],
                    host_command_word[dtc_pkg::CMD_SEL_LOW]};
  // Test runs only when healthy, selected and requested
  assign test_active = system_healthy && (mon_sel != 2'b00)
                       && host_command_word[dtc_pkg::CMD_RUN];

  // Half-period: upper frequency uses [15:0], lower uses [31:16]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_cnt_ff <= 32'h0000_0000;
      gen_ff <= 1'b0;
    end else if (gen_cnt_ff >= {16'h0000, host_command_word[dtc_pkg::CMD_LEVEL] ?
                 test_div_ff[15:0] : test_div_ff[31:16]}) begin
      gen_cnt_ff <= 32'h0000_0000;
      gen_ff <= !gen_ff;
    end else begin
      gen_cnt_ff <= gen_cnt_ff + 32'h0000_0001;
    end
  end

  // Blink at 1 Hz while testing
  logic [26:0] blink_cnt_ff;
  logic blink_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_ff <= 27'h000_0000;
      blink_ff <= 1'b0;
    end else if (!test_active) begin
      blink_cnt_ff <= 27'h000_0000;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == 27'(dtc_pkg::BLINK_HALF_CYC - 1)) begin
      blink_cnt_ff <= 27'h000_0000;
      blink_ff <= !blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 27'h000_0001;
    end
  end

  assign health_status_word = {system_healthy, test_active, !fwd_state_ff, fwd_state_ff,
                               msg_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs: relays, monitor routing, frequency outputs, LEDs
  function automatic logic relay_pick(input logic [3:0] code, input logic [7:0] st,
                                      input logic [3:0] lim, input logic fail);
    case (dtc_pkg::relay_src_t'(code))
      dtc_pkg::SRC_ON: relay_pick = 1'b1;
      dtc_pkg::SRC_LIMIT1: relay_pick = lim[0];
      dtc_pkg::SRC_LIMIT2: relay_pick = lim[1];
      dtc_pkg::SRC_LIMIT3: relay_pick = lim[2];
      dtc_pkg::SRC_LIMIT4: relay_pick = lim[3];
      dtc_pkg::SRC_MODULE: relay_pick = st[3];
      dtc_pkg::SRC_SUPPLIES: relay_pick = st[0] & st[1];
      dtc_pkg::SRC_SENSOR: relay_pick = st[2];
      dtc_pkg::SRC_SUPPLY1: relay_pick = st[0];
      dtc_pkg::SRC_SUPPLY2: relay_pick = st[1];
      dtc_pkg::SRC_FAILURE: relay_pick = fail;
      dtc_pkg::SRC_FWD: relay_pick = st[4];
      dtc_pkg::SRC_BWD: relay_pick = st[5];
      dtc_pkg::SRC_FWD_INV: relay_pick = !st[4];
      dtc_pkg::SRC_BWD_INV: relay_pick = !st[5];
      default: relay_pick = 1'b0;
    endcase
  endfunction : relay_pick

  function automatic logic freq_pick(input logic [2:0] code, input logic [3:0] f);
    case (code)
      3'h1: freq_pick = f[0];
      3'h2: freq_pick = f[1];
      3'h3: freq_pick = f[2];
      3'h4: freq_pick = f[3];
      default: freq_pick = 1'b0;
    endcase
  endfunction : freq_pick

  logic [3:0] fin;
  assign fin = {gen_ff, freq_input_three, freq_input_two, freq_input_one};

  // Relays ignore the indicator check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out <= 7'h00;
    end else begin
      for (int r = 0; r < 7; r++) begin
        relay_out[r] <= relay_pick(cfg_relay_ff[4*r +: 4], health_status_word,
                                   health_in.limits, failure_command);
      end
    end
  end

  // Selected monitor input takes the test signal during a test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_in <= 3'h0;
      freq_out <= 3'h0;
      freq_input_test <= 1'b0;
      peak_hold_clear <= 1'b0;
    end else begin
      freq_input_test <= gen_ff;
      for (int m = 0; m < 3; m++) begin
        monitor_in[m] <= (test_active && mon_sel == 2'(m + 1)) ? gen_ff : fin[m];
        freq_out[m] <= freq_pick(cfg_fout_ff[4*m +: 3], fin);
      end
      peak_hold_clear <= host_command_word[dtc_pkg::CMD_PEAK_CLR];
    end
  end

  // LEDs, all lit during indicator check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds <= '0;
    end else if (host_command_word[dtc_pkg::CMD_CHECK]) begin
      leds <= '1;
    end else begin
      leds.fwd_led <= fwd_state_ff;
      leds.bwd_led <= !fwd_state_ff;
      leds.ok_green <= system_healthy && (!test_active || blink_ff);
      leds.ok_red <= !system_healthy;
      leds.supply_one_led <= msg_ff[0];
      leds.supply_two_led <= msg_ff[1];
      leds.sensor_green <= msg_ff[2];
      leds.sensor_red <= !msg_ff[2];
      leds.limit_leds <= {~health_in.limits, health_in.limits};
      leds.ext_leds <= relay_out[6:3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_test_needs_health: assert property (@(posedge pclk) disable iff (!presetn)
    !system_healthy |-> !health_status_word[6]) else $error("test active with fault");
  a_select_gates_test: assert property (@(posedge pclk) disable iff (!presetn)
    mon_sel == 2'b00 |-> !test_active) else $error("test without monitor");
  a_force_fwd: assert property (@(posedge pclk) disable iff (!presetn)
    host_command_word[dtc_pkg::CMD_FWD_FORCE] |=> fwd_state_ff) else $error("force ignored");
  a_check_lamps: assert property (@(posedge pclk) disable iff (!presetn)
    host_command_word[dtc_pkg::CMD_CHECK] |=> leds == '1) else $error("lamp not lit");
  a_fault_red: assert property (@(posedge pclk) disable iff (!presetn)
    !system_healthy && !host_command_word[dtc_pkg::CMD_CHECK] |=> leds.ok_red && !leds.ok_green)
    else $error("fault lamps wrong");
  a_flags_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    health_status_word[4] != health_status_word[5]) else $error("direction flags clash");
  a_peak_follows: assert property (@(posedge pclk) disable iff (!presetn)
    peak_hold_clear == $past(host_command_word[dtc_pkg::CMD_PEAK_CLR]))
    else $error("peak clear wrong");
  a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    latch_cfg_ff[0] && !msg_ff[0] && !ack_done |=> !msg_ff[0]) else $error("latch lost");
  a_test_route: assert property (@(posedge pclk) disable iff (!presetn)
    test_active && mon_sel == 2'b01 |=> monitor_in[0] == $past(gen_ff))
    else $error("test not routed");

endmodule : direction_and_test_control

// file: common/dtc_pkg.sv
package dtc_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_DIR_OFF = 8'h00;
  localparam logic [7:0] CFG_RELAY_OFF = 8'h04;
  localparam logic [7:0] CFG_BIN_OFF = 8'h08;
  localparam logic [7:0] CFG_FOUT_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] TEST_DIV_OFF = 8'h18;
  localparam logic [7:0] HEALTH_OFF = 8'h1C;
  localparam logic [7:0] LATCH_CFG_OFF = 8'h20;
  // Command word bit positions
  localparam int CMD_SEL_LOW = 0;
  localparam int CMD_SEL_HIGH = 1;
  localparam int CMD_LEVEL = 2;
  localparam int CMD_RUN = 3;
  localparam int CMD_CHECK = 4;
  localparam int CMD_ACK = 5;
  localparam int CMD_PEAK_CLR = 6;
  localparam int CMD_FWD_FORCE = 7;
  // Reset values
  localparam logic [31:0] CFG_DIR_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RELAY_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_BIN_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_FOUT_RST = 32'h0000_0000;
  localparam logic [31:0] TEST_DIV_RST = 32'h0000_1388;
  // Blink timing: 1 Hz at 100 MHz, toggle every half period
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // Relay source codes
  typedef enum logic [3:0] {
    SRC_OFF, SRC_ON, SRC_LIMIT1, SRC_LIMIT2, SRC_LIMIT3, SRC_LIMIT4,
    SRC_MODULE, SRC_SUPPLIES, SRC_SENSOR, SRC_SUPPLY1, SRC_SUPPLY2,
    SRC_FAILURE, SRC_FWD, SRC_BWD, SRC_FWD_INV, SRC_BWD_INV
  } relay_src_t;
  // Binary input functions
  typedef enum logic [3:0] {
    BIN_NONE, BIN_ACK, BIN_PEAK_CLR, BIN_CHECK, BIN_FWD_FORCE,
    BIN_SEL_LOW, BIN_SEL_HIGH, BIN_LEVEL, BIN_RUN, BIN_TEST_ACTIVE
  } bin_func_t;
  // Health flags from the monitoring side
  typedef struct packed {
    logic self_test_ok;
    logic supply_one_healthy;
    logic supply_two_healthy;
    logic sensor_healthy;
    logic [3:0] limits;
  } health_in_t;
  // Indicator outputs
  typedef struct packed {
    logic fwd_led;
    logic bwd_led;
    logic ok_green;
    logic ok_red;
    logic supply_one_led;
    logic supply_two_led;
    logic sensor_green;
    logic sensor_red;
    logic [7:0] limit_leds;
    logic [3:0] ext_leds;
  } leds_t;
endpackage : dtc_pkg

// file: testbench/sensor_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Three sensor pulse trains a third of a period apart; reverse flips the order
module sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reverse,
  input wire logic [2:0] alive,
  output logic [2:0] pulses
);
  logic [3:0] phase_ff;
  // Twelve-cycle wheel position counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= (phase_ff == 4'hB) ? 4'h0 : phase_ff + 4'h1;
    end
  end
  // A lost sensor sits low like a dead pickup
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pulses[i] = alive[i] & (((int'(phase_ff) + (reverse ? 4 * i : 12 - 4 * i)) % 12) < 6);
    end
  end
endmodule : sensor_model

// file: testbench/direction_and_test_control_bench.sv
`timescale 1ns/10ps
module direction_and_test_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic [2:0] fin = 3'h0;
  logic [5:0] binary_in = 6'h00;
  dtc_pkg::health_in_t health_in = 8'hF0;
  logic [6:0] relay_out;
  logic [2:0] freq_out;
  logic freq_input_test;
  logic [2:0] monitor_in;
  logic peak_hold_clear;
  dtc_pkg::leds_t leds;
  logic reverse = 1'b0;
  logic [2:0] alive = 3'h7;
  logic [2:0] pulses;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int c;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hA};
  logic [8:0] dir_cases [8] = '{9'h136, 9'h037, 9'h16C, 9'h17E, 9'h07F, 9'h17A, 9'h07D, 9'h0B6};
  logic [31:0] q;
  logic [31:0] cfg;
  logic [11:0] fsel;
  logic [2:0] sv;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 pclk = ~pclk;
  direction_and_test_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .sensor_pulse_one(pulses[0]), .sensor_pulse_two(pulses[1]),
    .sensor_pulse_three(pulses[2]), .freq_input_one(fin[0]), .freq_input_two(fin[1]),
    .freq_input_three(fin[2]), .binary_in(binary_in), .health_in(health_in),
    .relay_out(relay_out), .freq_out(freq_out), .freq_input_test(freq_input_test),
    .monitor_in(monitor_in), .peak_hold_clear(peak_hold_clear), .leds(leds));
  sensor_model wheel (.pclk(pclk), .presetn(presetn), .reverse(reverse), .alive(alive),
    .pulses(pulses));
  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready, then one idle edge
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdata);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask : rreg
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Relay level expected for a source code with healthy supplies
  function automatic logic relay_expect(input logic [3:0] code);
    case (code)
      4'h1, 4'h9, 4'hA: return 1'b1;
      4'h2, 4'h3, 4'h4, 4'h5: return health_in.limits[code - 4'h2];
      default: return 1'b0;
    endcase
  endfunction : relay_expect
  // Cycles between two toggles of the test generator
  task automatic half_period(output int cnt);
    logic last;
    cnt = 0;
    last = freq_input_test;
    do begin
      @(posedge pclk);
      cnt++;
    end while (freq_input_test === last);
    last = freq_input_test;
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (freq_input_test === last);
  endtask : half_period
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(31));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rreg(dtc_pkg::CFG_DIR_OFF, q);
    check("direction config", q, dtc_pkg::CFG_DIR_RST);
    rreg(dtc_pkg::TEST_DIV_OFF, q);
    check("test divider", q, dtc_pkg::TEST_DIV_RST);
    rreg(8'hFC, q);
    check("unmapped", q, 32'h0);
    // Random relay and frequency output routing
    for (int k = 0; k < 6; k++) begin
      cfg = 32'h0;
      for (int r = 0; r < 7; r++) cfg[4 * r +: 4] = codes[$urandom_range(7)];
      fsel = {4'(k % 4), 4'($urandom_range(3)), 4'(3 - k % 4)};
      health_in <= {4'hF, 4'($urandom)};
      fin <= 3'($urandom);
      wreg(dtc_pkg::CFG_RELAY_OFF, cfg);
      wreg(dtc_pkg::CFG_FOUT_OFF, {20'h0, fsel});
      repeat (6) @(posedge pclk);
      for (int r = 0; r < 7; r++) check("relay", relay_out[r], relay_expect(cfg[4 * r +: 4]));
      for (int o = 0; o < 3; o++) check("freq out", freq_out[o], (fsel[4 * o +: 4] == 4'h0) ? 1'b0 : fin[fsel[4 * o +: 4] - 4'h1]);
    end
    // Direction from phase order, lost sensors and polarity
    health_in <= 8'hF0;
    foreach (dir_cases[i]) begin
      reverse <= dir_cases[i][0];
      alive <= dir_cases[i][3:1];
      wreg(dtc_pkg::CFG_DIR_OFF, {27'h0, dir_cases[i][6:4], dir_cases[i][7], 1'b0});
      repeat (200) @(posedge pclk);
      rreg(dtc_pkg::STATUS_OFF, q);
      check("direction", q[5:4], {~dir_cases[i][8], dir_cases[i][8]});
    end
    // Forward force and indicator check through binary inputs
    reverse <= 1'b1;
    alive <= 3'h3;
    wreg(dtc_pkg::CFG_BIN_OFF, 32'h0000_0340);
    wreg(dtc_pkg::CFG_RELAY_OFF, 32'h0000_001C);
    wreg(dtc_pkg::CFG_DIR_OFF, 32'h0000_000C);
    repeat (200) @(posedge pclk);
    check("backward relay", relay_out, 7'h02);
    binary_in <= 6'h02;
    repeat (20) @(posedge pclk);
    check("forced relay", relay_out, 7'h03);
    binary_in <= 6'h00;
    wreg(dtc_pkg::CFG_RELAY_OFF, 32'h0000_0010);
    binary_in <= 6'h04;
    repeat (20) @(posedge pclk);
    check("lamp leds", leds, 32'h000F_FFFF);
    check("lamp relays", relay_out, 7'h02);
    binary_in <= 6'h00;
    wreg(dtc_pkg::CFG_BIN_OFF, 32'h0);
    wreg(dtc_pkg::TEST_DIV_OFF, 32'h0007_0004);
    // Every monitor selection at both test levels
    for (int s = 0; s < 8; s++) begin
      sv = 3'(s);
      wreg(dtc_pkg::CMD_OFF, {28'h0, 1'b1, sv});
      repeat (8) @(posedge pclk);
      rreg(dtc_pkg::STATUS_OFF, q);
      check("test active", q[6], sv[1:0] != 2'b00);
      // Selected monitor carries the test signal, the others their own input
      for (int m = 0; m < 3; m++) begin
        check("monitor in", monitor_in[m], (sv[1:0] == 2'(m + 1)) ? freq_input_test : fin[m]);
      end
      if (sv[1:0] != 2'b00) begin
        // Generator counts from zero up to the stored value, so N plus one cycles
        half_period(c);
        check("half period", 32'(c), sv[2] ? 32'h5 : 32'h8);
      end
    end
    // A fault blocks the test and swaps the health lamps
    health_in <= 8'h70;
    wreg(dtc_pkg::CMD_OFF, 32'h9);
    repeat (8) @(posedge pclk);
    rreg(dtc_pkg::STATUS_OFF, q);
    check("test under fault", q[7:6], 2'b00);
    check("health lamps", {leds.ok_green, leds.ok_red}, 2'b01);
    health_in <= 8'hF0;
    wreg(dtc_pkg::CMD_OFF, 32'h40);
    repeat (8) @(posedge pclk);
    rreg(dtc_pkg::STATUS_OFF, q);
    check("test ended", q[6], 1'b0);
    check("peak clear", peak_hold_clear, 1'b1);
    // Test started from binary inputs alone
    wreg(dtc_pkg::CMD_OFF, 32'h0);
    wreg(dtc_pkg::CFG_BIN_OFF, 32'h0005_8000);
    binary_in <= 6'h18;
    repeat (20) @(posedge pclk);
    rreg(dtc_pkg::STATUS_OFF, q);
    check("binary test", q[6], 1'b1);
    tally_and_finish();
  end
endmodule : direction_and_test_control_bench
